// >>> core/arx_pkg.sv
// arx_pkg: constants for the converter result table and external mux decode
// assumes a 16-bit host bus with byte address, byte lanes, single-cycle access
`default_nettype none
package arx_pkg;
  // result table geometry
  localparam int unsigned RES_DEPTH      = 64;
  localparam int unsigned RES_WIDTH      = 10;
  localparam int unsigned IDX_WIDTH      = 6;
  localparam int unsigned ADDR_WIDTH     = 24;
  // byte addresses of the three views, 128 bytes each
  localparam logic [23:0] RIGHT_UNS_BASE = 24'hCA0280;
  localparam logic [23:0] LEFT_SGN_BASE  = 24'hCA0300;
  localparam logic [23:0] LEFT_UNS_BASE  = 24'hCA0380;
  localparam logic [23:0] VIEW_SPAN      = 24'h000080;
  // field positions inside a view
  localparam int unsigned LEFT_LSB       = 6;
  localparam int unsigned SIGN_BIT       = 15;
  // reset value of the select outputs; RES_RESET is unused, stored entries are not reset
  localparam logic [9:0]  RES_RESET      = 10'h000;
  localparam logic [1:0]  SEL_RESET      = 2'h0;
  // channel codes
  localparam logic [5:0]  CH_PORT_A0     = 6'h34;
  localparam logic [5:0]  CH_PORT_A1     = 6'h35;
  localparam logic [5:0]  CH_REF_LOW     = 6'h3C;
  localparam logic [5:0]  CH_REF_MID     = 6'h3E;
  localparam logic [5:0]  CH_END_QUEUE   = 6'h3F;
  // multiplexed decode patterns: bits 5:3 and group bit 0
  localparam logic [2:0]  MUX_HI_WX      = 3'h0;
  localparam logic [2:0]  MUX_HI_YZ      = 3'h2;
  // view selector
  typedef enum logic [1:0] {
    VIEW_NONE, VIEW_RIGHT_UNS, VIEW_LEFT_SGN, VIEW_LEFT_UNS
  } arx_view_t;
  // channel classes
  typedef enum logic [2:0] {
    CH_DIRECT, CH_EXT_W, CH_EXT_X, CH_EXT_Y, CH_EXT_Z, CH_REFERENCE,
    CH_END, CH_INVALID
  } arx_chan_t;
endpackage : arx_pkg
`default_nettype wire

// >>> core/arx_mux_if.sv
// arx_mux_if: channel decode request and answer between top and decoder
// assumes one clock; decoder is purely combinational
`default_nettype none
interface arx_mux_if;
  import arx_pkg::*;
  logic [5:0] chan_code;  // channel field of the running command word
  logic       ext_mode;   // external multiplexing enabled
  arx_chan_t  chan_class; // decoded class of the channel
  logic [1:0] select;     // external select value for the code
  modport top (output chan_code, output ext_mode,
               input chan_class, input select);
  modport dec (input chan_code, input ext_mode,
               output chan_class, output select);
endinterface : arx_mux_if
`default_nettype wire

// >>> core/arx_chan_decode.sv
// arx_chan_decode: classifies a channel code for either assignment mode
// assumes the caller registers the answer before driving pins
`default_nettype none
module arx_chan_decode
  import arx_pkg::*;
(
  // decode link
  arx_mux_if.dec mux
);
  // classification of the code
  always_comb begin
    mux.select     = mux.chan_code[2:1];
    mux.chan_class = CH_INVALID;
    if (mux.chan_code == CH_END_QUEUE) begin
      mux.chan_class = CH_END;
    end else if (mux.chan_code >= CH_REF_LOW &&
                 mux.chan_code <= CH_REF_MID) begin
      mux.chan_class = CH_REFERENCE;
    end else if (mux.ext_mode) begin
      // select lines freed from port use, codes 52/53 dead
      if (mux.chan_code[5:3] == MUX_HI_WX) begin
        mux.chan_class = mux.chan_code[0] ? CH_EXT_X : CH_EXT_W;
      end else if (mux.chan_code[5:3] == MUX_HI_YZ) begin
        mux.chan_class = mux.chan_code[0] ? CH_EXT_Z : CH_EXT_Y;
      end else if (mux.chan_code == CH_PORT_A0 ||
                   mux.chan_code == CH_PORT_A1) begin
        mux.chan_class = CH_INVALID;
      end else if (mux.chan_code > CH_PORT_A1 &&
                   mux.chan_code < CH_REF_LOW) begin
        mux.chan_class = CH_DIRECT;
      end
    end else begin
      // direct inputs: low codes and port A lines
      if (mux.chan_code <= 6'h03 ||
          (mux.chan_code >= CH_PORT_A0 && mux.chan_code < CH_REF_LOW)) begin
        mux.chan_class = CH_DIRECT;
      end
    end
  end
endmodule : arx_chan_decode
`default_nettype wire

// >>> core/arx_view_fmt.sv
// arx_view_fmt: formats one stored outcome into the three read views
// assumes a ten-bit unsigned outcome at its input
`default_nettype none
module arx_view_fmt
  import arx_pkg::*;
(
  // stored outcome
  input  wire logic [9:0]  outcome,
  input  wire arx_view_t   view,
  // formatted half-word
  output logic      [15:0] half
);
  // view formatting; low bits and unused bits read zero
  always_comb begin
    unique case (view)
      VIEW_RIGHT_UNS: half = {6'h00, outcome};
      VIEW_LEFT_SGN:  half = {~outcome[9], outcome[8:0], 6'h00};
      VIEW_LEFT_UNS:  half = {outcome, 6'h00};
      VIEW_NONE:      half = 16'h0000;
    endcase
  end
endmodule : arx_view_fmt
`default_nettype wire

// >>> core/arx_result_table.sv
// arx_result_table: result RAM, three host views, external mux selects
// assumes converter strobes a done pulse with index and outcome, and
// a host bus with one-cycle select, byte lanes and registered read data
`default_nettype none
module arx_result_table
  import arx_pkg::*;
#(
  parameter int unsigned DEPTH = RES_DEPTH,
  parameter int unsigned WIDTH = RES_WIDTH
)
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // wider converter state
  input  wire logic                  stop_mode,
  input  wire logic                  ext_mux_enable,
  input  wire logic [1:0]            port_a_direction,
  // conversion engine side
  input  wire logic                  conv_start,
  input  wire logic [5:0]            conv_chan,
  input  wire logic                  conv_done,
  input  wire logic [IDX_WIDTH-1:0]  conv_index,
  input  wire logic [WIDTH-1:0]      conv_outcome,
  // host bus
  input  wire logic                  bus_sel,
  input  wire logic                  bus_write,
  input  wire logic [ADDR_WIDTH-1:0] bus_addr,
  input  wire logic [1:0]            bus_byte_en,
  input  wire logic [15:0]           bus_wdata,
  output logic      [15:0]           bus_rdata,
  output logic                       bus_ack,
  output logic                       bus_error,
  // external mux pins
  output logic      [1:0]            ext_select_lines,
  output logic      [1:0]            ext_select_oe,
  output logic                       ext_mode_active,
  output arx_chan_t                  chan_class
);
  // result storage, one entry per command word position
  logic [WIDTH-1:0] result_mem [DEPTH];
  // decoded view and index of the current access
  arx_view_t            acc_view;
  logic [IDX_WIDTH-1:0] acc_index;
  logic [15:0]          fmt_half;
  logic [WIDTH-1:0]     rd_word;
  logic [WIDTH-1:0]     next_entry;
  logic                 host_wr;
  arx_mux_if            mux ();

  // view decode from byte address; half-word index from bits 6:1
  function automatic arx_view_t view_of(input logic [23:0] a);
    arx_view_t v;
    v = VIEW_NONE;
    if (a >= RIGHT_UNS_BASE && a < RIGHT_UNS_BASE + VIEW_SPAN)
      v = VIEW_RIGHT_UNS;
    else if (a >= LEFT_SGN_BASE && a < LEFT_SGN_BASE + VIEW_SPAN)
      v = VIEW_LEFT_SGN;
    else if (a >= LEFT_UNS_BASE && a < LEFT_UNS_BASE + VIEW_SPAN)
      v = VIEW_LEFT_UNS;
    return v;
  endfunction : view_of

  // all three windows alias the same entry
  assign acc_view  = view_of(bus_addr);
  assign acc_index = bus_addr[IDX_WIDTH:1];
  assign rd_word   = result_mem[acc_index];
  // blocked in stop mode: writes anytime except then
  assign host_wr   = bus_sel && bus_write && !stop_mode &&
                     acc_view != VIEW_NONE;

  // host write: only result bits land, zero bits drop silently
  always_comb begin
    next_entry = rd_word;
    unique case (acc_view)
      VIEW_RIGHT_UNS: begin
        if (bus_byte_en[0]) next_entry[7:0] = bus_wdata[7:0];
        if (bus_byte_en[1]) next_entry[9:8] = bus_wdata[9:8];
      end
      VIEW_LEFT_SGN: begin
        if (bus_byte_en[1]) next_entry[9:2] =
          {~bus_wdata[SIGN_BIT], bus_wdata[14:8]};
        if (bus_byte_en[0]) next_entry[1:0] = bus_wdata[7:6];
      end
      VIEW_LEFT_UNS: begin
        if (bus_byte_en[1]) next_entry[9:2] = bus_wdata[15:8];
        if (bus_byte_en[0]) next_entry[1:0] = bus_wdata[7:6];
      end
      VIEW_NONE: next_entry = rd_word;
    endcase
  end

  // formatter for the read path
  arx_view_fmt u_fmt (
    .outcome (rd_word),
    .view    (acc_view),
    .half    (fmt_half)
  );

  // storage update; conversion wins over a host write to the same entry
  // so a fresh outcome is never lost
  always_ff @(posedge core_clk) begin
    if (host_wr && !(conv_done && conv_index == acc_index)) begin
      result_mem[acc_index] <= next_entry;
    end
    if (conv_done) begin
      result_mem[conv_index] <= conv_outcome;
    end
  end

  // bus answer: one cycle, never an error for mapped windows
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_ack   <= 1'b0;
      bus_error <= 1'b0;
      bus_rdata <= 16'h0000;
    end else begin
      bus_ack   <= bus_sel && acc_view != VIEW_NONE;
      bus_error <= bus_sel && acc_view == VIEW_NONE;
      if (bus_sel && !bus_write) begin
        // reads in stop mode carry no meaning; zero is returned
        bus_rdata <= stop_mode ? 16'h0000 : fmt_half;
      end
    end
  end

  // channel decode of the command word being started
  assign mux.chan_code = conv_chan;
  assign mux.ext_mode  = ext_mux_enable;

  arx_chan_decode u_dec (
    .mux (mux.dec)
  );

  // select outputs latched at conversion start, held through sampling;
  // direction bits are deliberately not consulted
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_select_lines <= SEL_RESET;
      ext_select_oe    <= 2'h0;
      ext_mode_active  <= 1'b0;
      chan_class       <= CH_INVALID;
    end else begin
      ext_mode_active <= ext_mux_enable;
      ext_select_oe   <= ext_mux_enable ? 2'h3 : 2'h0;
      if (conv_start) begin
        ext_select_lines <= mux.select;
        chan_class       <= mux.chan_class;
      end
    end
  end

  // port_a_direction has no say in external mode
  logic dir_unused;
  assign dir_unused = ^port_a_direction;

  // signed view code points at the limits
  AST_SIGNED_FULL: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (acc_view == VIEW_LEFT_SGN && rd_word == 10'h3FF) |->
      fmt_half == 16'h7FC0)
    else $error("signed full scale wrong");
  AST_SIGNED_MID: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (acc_view == VIEW_LEFT_SGN && rd_word == 10'h200) |->
      fmt_half == 16'h0000)
    else $error("signed midscale wrong");
  AST_SIGNED_ZERO: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (acc_view == VIEW_LEFT_SGN && rd_word == 10'h000) |->
      fmt_half == 16'h8000)
    else $error("signed zero wrong");
  // read views and bus answer; only written entries are meaningful
  AST_RIGHT_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && !bus_write && !stop_mode && acc_view == VIEW_RIGHT_UNS) |=>
      bus_rdata[15:10] == 6'h00 && bus_ack)
    else $error("right view upper bits set");
  AST_RIGHT_FULL: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && !bus_write && !stop_mode && acc_view == VIEW_RIGHT_UNS) |=>
      bus_rdata == {6'h00, $past(rd_word)})
    else $error("right view value wrong");
  AST_LEFT_LOW: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && !bus_write && !stop_mode && acc_view == VIEW_LEFT_UNS) |=>
      bus_rdata[5:0] == 6'h00)
    else $error("left view low bits set");
  AST_LEFT_FULL: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && !bus_write && !stop_mode && acc_view == VIEW_LEFT_UNS) |=>
      bus_rdata == {$past(rd_word), 6'h00})
    else $error("left view value wrong");
  AST_SIGNED_FMT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && !bus_write && acc_view == VIEW_LEFT_SGN) |->
      fmt_half[15] != rd_word[9] && fmt_half[14:6] == rd_word[8:0] &&
      fmt_half[5:0] == 6'h00)
    else $error("signed view layout wrong");
  AST_STOP_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && !bus_write && stop_mode) |=>
      bus_rdata == 16'h0000)
    else $error("stop mode read not zero");
  AST_NO_ERROR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && acc_view != VIEW_NONE) |=>
      bus_ack && !bus_error)
    else $error("mapped access errored");
  AST_UNMAPPED: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && acc_view == VIEW_NONE) |=>
      bus_error && !bus_ack)
    else $error("unmapped access not flagged");
  AST_ACK_PULSE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !bus_sel |=>
      !bus_ack && !bus_error)
    else $error("answer without access");
  // storage updates from both sides
  AST_CONV_STORE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    conv_done |=>
      result_mem[$past(conv_index)] == $past(conv_outcome))
    else $error("conversion not stored");
  AST_HOST_RIGHT_WR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (host_wr && acc_view == VIEW_RIGHT_UNS && bus_byte_en == 2'h3 &&
     !conv_done) |=>
      {6'h00, result_mem[$past(acc_index)]} ==
        ($past(bus_wdata) & 16'h03FF))
    else $error("right view write wrong");
  AST_HOST_LEFT_WR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (host_wr && acc_view == VIEW_LEFT_UNS && bus_byte_en == 2'h3 &&
     !conv_done) |=>
      {result_mem[$past(acc_index)], 6'h00} ==
        ($past(bus_wdata) & 16'hFFC0))
    else $error("left view write wrong");
  AST_HOST_SGN_WR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (host_wr && acc_view == VIEW_LEFT_SGN && bus_byte_en == 2'h3 &&
     !conv_done) |=>
      {~result_mem[$past(acc_index)][9],
       result_mem[$past(acc_index)][8:0], 6'h00} ==
        ($past(bus_wdata) & 16'hFFC0))
    else $error("signed view write wrong");
  AST_STOP_WRITE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_sel && bus_write && stop_mode && acc_view != VIEW_NONE &&
     !conv_done) |=>
      result_mem[$past(acc_index)] == $past(rd_word))
    else $error("stop mode write landed");
  // select outputs and channel decode
  AST_SEL_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !conv_start |=>
      $stable(ext_select_lines))
    else $error("select moved without start");
  AST_SEL_LOAD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    conv_start |=>
      (($past(conv_chan) >> 1) & 6'h03) ==
        {4'h0, ext_select_lines})
    else $error("select not from code bits");
  AST_MODE_OE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    ext_mux_enable |=>
      ext_select_oe == 2'h3 && ext_mode_active)
    else $error("select outputs not driven");
  AST_OE_OFF: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !ext_mux_enable |=>
      ext_select_oe == 2'h0 && !ext_mode_active)
    else $error("select outputs driven off mode");
  AST_DEAD_CODE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (conv_start && ext_mux_enable && conv_chan == CH_PORT_A0) |=>
      chan_class == CH_INVALID)
    else $error("code 52 live in mux mode");
  AST_DEAD_CODE_HI: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (conv_start && ext_mux_enable && conv_chan == CH_PORT_A1) |=>
      chan_class == CH_INVALID)
    else $error("code 53 live in mux mode");
  AST_REF_CLASS: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (conv_start && conv_chan >= CH_REF_LOW &&
     conv_chan <= CH_REF_MID) |=>
      chan_class == CH_REFERENCE)
    else $error("reference code misread");
  AST_END_CLASS: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (conv_start && conv_chan == CH_END_QUEUE) |=>
      chan_class == CH_END)
    else $error("end marker misread");
  AST_EXT_GROUP_W: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (conv_start && ext_mux_enable && conv_chan[5:3] == MUX_HI_WX &&
     !conv_chan[0]) |=>
      chan_class == CH_EXT_W)
    else $error("group w code misread");
endmodule : arx_result_table
`default_nettype wire

// >>> testbench/arx_mux_model.sv
// arx_mux_model: four external 4-input muxes sharing two select lines
// assumes select outputs drive all muxes only while both enables are high
`default_nettype none
module arx_mux_model
  import arx_pkg::*;
(
  // select pins from the block
  input  wire logic [1:0] select,
  input  wire logic [1:0] oe,
  // which of four inputs each mux routes, and whether selects are valid
  output logic      [1:0] routed,
  output logic            driven
);
  timeunit 1ns;
  timeprecision 1ps;
  // every mux follows the same shared selects
  always_comb begin
    driven = (oe == 2'h3); // undriven pins give no valid route
    routed = driven ? select : ~select;
  end
endmodule : arx_mux_model
`default_nettype wire

// >>> testbench/tb_top.sv
// tb_top: self-checking bench for the result table and mux decode
// assumes one 20 MHz clock and inputs driven 5 ns after each rising edge
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import arx_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, stop_mode = 1'b0, ext_en = 1'b0;
  logic [1:0] dir = 2'h0, be = 2'h0, sel_l, sel_oe, routed;
  logic conv_start = 1'b0, conv_done = 1'b0, sel = 1'b0, wr = 1'b0;
  logic [5:0] conv_chan = 6'h00, conv_index = 6'h00;
  logic [9:0] conv_outcome = 10'h000;
  logic [23:0] addr = 24'h000000;
  logic [15:0] wdata = 16'h0000, rdata, rd;
  logic ack, err, mode_act, driven;
  arx_chan_t cls;
  int errors = 0, total_checks = 0;
  // clock and design under test
  always #25 core_clk = ~core_clk;
  arx_result_table u_arx_result_table (.core_clk(core_clk), .rst_n(rst_n),
    .stop_mode(stop_mode), .ext_mux_enable(ext_en), .port_a_direction(dir),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_index(conv_index), .conv_outcome(conv_outcome), .bus_sel(sel),
    .bus_write(wr), .bus_addr(addr), .bus_byte_en(be), .bus_wdata(wdata),
    .bus_rdata(rdata), .bus_ack(ack), .bus_error(err),
    .ext_select_lines(sel_l), .ext_select_oe(sel_oe),
    .ext_mode_active(mode_act), .chan_class(cls));
  arx_mux_model u_arx_mux_model (.select(sel_l), .oe(sel_oe),
    .routed(routed), .driven(driven));
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // one host access; entered and left 5 ns after an edge
  task automatic bus(input logic w, input logic [23:0] a,
                     input logic [1:0] b, input logic [15:0] d,
                     input logic exp_err);
    {sel, wr, addr, be, wdata} = {1'b1, w, a, b, d};
    @(posedge core_clk);
    #5 {sel, conv_done} = 2'b00; // the access is taken at that edge
    check("ack", ack, !exp_err);
    check("error", err, exp_err);
    rd = rdata;
    @(posedge core_clk);
    #5;
  endtask : bus
  // one finished conversion into an entry
  task automatic conv(input logic [5:0] i, input logic [9:0] o);
    {conv_done, conv_index, conv_outcome} = {1'b1, i, o};
    @(posedge core_clk);
    #5 conv_done = 1'b0;
  endtask : conv
  // all three views of several outcomes, edge indices included
  task automatic t_views();
    logic [9:0] o;
    logic [23:0] off;
    for (int k = 0; k < 4; k++) begin
      o = (k == 0) ? 10'h3FF : (k == 1) ? 10'h200 : (k == 2) ? 10'h000
        : 10'h155;
      off = {17'h0, 6'(k * 21), 1'b0};
      conv(6'(k * 21), o);
      bus(1'b0, RIGHT_UNS_BASE + off, 2'h3, 16'h0000, 1'b0);
      check("right", rd, {6'h00, o});
      bus(1'b0, LEFT_SGN_BASE + off, 2'h3, 16'h0000, 1'b0);
      check("signed", rd, {~o[9], o[8:0], 6'h00});
      if (k < 3)
        check("sgn fixed", rd, (k == 0) ? 16'h7FC0 : (k == 1) ? 16'h0000
          : 16'h8000);
      bus(1'b0, LEFT_UNS_BASE + off, 2'h3, 16'h0000, 1'b0);
      check("left", rd, {o, 6'h00});
    end
    // coherent pair: no conversion runs while both are read
    bus(1'b0, RIGHT_UNS_BASE, 2'h3, 16'h0000, 1'b0);
    check("set first", rd, 16'h03FF);
    bus(1'b0, RIGHT_UNS_BASE + 24'h7E, 2'h3, 16'h0000, 1'b0);
    check("set last", rd, 16'h0155);
  endtask : t_views
  // byte and half-word writes, zero bits, signed write, stop, unmapped
  task automatic t_host();
    bus(1'b1, RIGHT_UNS_BASE + 24'h4, 2'h3, 16'hFFFF, 1'b0);
    bus(1'b0, RIGHT_UNS_BASE + 24'h4, 2'h3, 16'h0000, 1'b0);
    check("zero bits", rd, 16'h03FF);
    bus(1'b1, RIGHT_UNS_BASE + 24'h4, 2'h1, 16'hEE12, 1'b0);
    bus(1'b1, RIGHT_UNS_BASE + 24'h4, 2'h2, 16'h0133, 1'b0);
    bus(1'b0, RIGHT_UNS_BASE + 24'h4, 2'h3, 16'h0000, 1'b0);
    check("byte lanes", rd, 16'h0112);
    bus(1'b1, LEFT_SGN_BASE + 24'h6, 2'h3, 16'h0000, 1'b0);
    bus(1'b0, RIGHT_UNS_BASE + 24'h6, 2'h3, 16'h0000, 1'b0);
    check("signed write", rd, 16'h0200);
    bus(1'b1, LEFT_UNS_BASE + 24'hA, 2'h3, 16'hABFF, 1'b0);
    bus(1'b0, RIGHT_UNS_BASE + 24'hA, 2'h3, 16'h0000, 1'b0);
    check("left write", rd, 16'h02AF);
    stop_mode = 1'b1;
    bus(1'b1, RIGHT_UNS_BASE + 24'h6, 2'h3, 16'h0055, 1'b0);
    bus(1'b0, RIGHT_UNS_BASE + 24'h6, 2'h3, 16'h0000, 1'b0);
    check("stop read", rd, 16'h0000);
    stop_mode = 1'b0;
    bus(1'b0, RIGHT_UNS_BASE + 24'h6, 2'h3, 16'h0000, 1'b0);
    check("stop write", rd, 16'h0200);
    bus(1'b0, 24'h000000, 2'h3, 16'h0000, 1'b1);
    // conversion lands on the entry while the host writes it
    {conv_done, conv_index, conv_outcome} = {1'b1, 6'h04, 10'h2AA};
    bus(1'b1, RIGHT_UNS_BASE + 24'h8, 2'h3, 16'h0111, 1'b0);
    bus(1'b0, RIGHT_UNS_BASE + 24'h8, 2'h3, 16'h0000, 1'b0);
    check("overwrite", rd, 16'h02AA);
    // a read does not hold off an update of another entry
    {conv_done, conv_index, conv_outcome} = {1'b1, 6'h01, 10'h0AB};
    bus(1'b0, RIGHT_UNS_BASE, 2'h3, 16'h0000, 1'b0);
    check("read during conv", rd, 16'h03FF);
    bus(1'b0, RIGHT_UNS_BASE + 24'h2, 2'h3, 16'h0000, 1'b0);
    check("other entry", rd, 16'h00AB);
  endtask : t_host
  // one command word start and its decoded class and selects
  task automatic mux(input logic [5:0] c, input arx_chan_t exp);
    {conv_start, conv_chan} = {1'b1, c};
    @(posedge core_clk);
    #5 conv_start = 1'b0;
    check("class", 16'(cls), 16'(exp));
    check("oe", sel_oe, ext_en ? 2'h3 : 2'h0);
    check("active", mode_act, ext_en);
    if (ext_en) begin
      check("select", sel_l, c[2:1]);
      check("routed", routed, c[2:1]);
    end
    // let an edge pass so the next start is a fresh pulse
    @(posedge core_clk);
    #5;
  endtask : mux
  // decode in both assignment modes, direction bits toggled
  task automatic t_mux();
    mux(6'h01, CH_DIRECT);
    mux(6'h3E, CH_REFERENCE);
    mux(6'h3F, CH_END);
    mux(CH_PORT_A0, CH_DIRECT);
    mux(6'h10, CH_INVALID);
    ext_en = 1'b1;
    dir = 2'h3;
    @(posedge core_clk);
    #5;
    mux(6'h06, CH_EXT_W);
    mux(6'h03, CH_EXT_X);
    mux(6'h14, CH_EXT_Y);
    mux(6'h17, CH_EXT_Z);
    mux(CH_PORT_A0, CH_INVALID);
    mux(CH_PORT_A1, CH_INVALID);
    mux(6'h37, CH_DIRECT);
    mux(6'h08, CH_INVALID);
    for (int c = 60; c < 63; c++) mux(6'(c), CH_REFERENCE);
    mux(CH_END_QUEUE, CH_END);
  endtask : t_mux
  // verdict
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // main sequence: reset held four cycles
  initial begin
    repeat (4) @(posedge core_clk);
    #5 rst_n = 1'b1;
    check("reset class", 16'(cls), 16'(CH_INVALID));
    t_views();
    t_host();
    t_mux();
    summarize();
  end
  // watchdog well beyond the hundred or so cycles needed
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
